// ---- rtl/bcit_core.v ----
// Instruction decode and timing top: classifies an opcode, forms branch targets,
// counts execution clocks, and holds the data pointer and stack pointer registers.
// Assumes opcode and operand bytes are presented with a one-cycle start strobe.
//
// Behaviour
// [RL1] Clear, rotates, swap take 1 clock; complement takes 2; all single-byte.
// [RL2] Logic op immediate into direct byte: three bytes, 3 clocks.
// [RL3] Accumulator-indirect RAM moves take 2 clocks; bank register moves 1.
// [RL4] Data pointer immediate load: three bytes, 3 clocks.
// [RL5] Code read via data pointer 4-7 clocks; via program counter 3.
// [RL6] External data transfers: single byte, 3 clocks.
// [RL7] Push and pop direct: two bytes, 2 clocks.
// [RL8] Carry-only ops 1 clock; carry with direct bit two bytes, 2 clocks.
// [RL9] Two-byte conditional jumps: 2 not taken, 4-6 taken.
// [RL10] Bit-test jumps 3 or 5-7; test-and-clear clears a set bit.
// [RL11] Page/short jumps 4-6, long 5-7, returns 6-8 clocks.
// [RL12] Indirect jump via accumulator plus data pointer: one byte, 3-5.
// [RL13] Compare jumps three bytes; direct/indirect 4 or 6-8; register 3 or 5-7.
// [RL14] Register decrement jump 2 or 4-6; direct form three bytes, 3 or 5-7.
// [RL15] Relative offset is signed 8-bit, added to next instruction address.
// [RL16] Direct operand below 0x80 selects RAM, else special registers.
// [RL17] Page target stays in 2 kB page of next instruction.
// [RL18] Long target reaches whole 64 kB space.
// [RL19] Unused opcode 0xa5 behaves as one-byte one-clock no-operation.
// [RL20] Bank registers R0-R7 of selected bank; indirect uses R0 or R1.
// [RL21] Counts vary with alignment and flash read timing within ranges.
// [RL22] Data pointer low byte at 0x82, read/write, resets to zero.
// [RL23] Data pointer high byte at 0x83, read/write, resets to zero.
// [RL24] Stack pointer increments before push write; resets to 0x07.
// [RL25] Most instructions take as many clocks as bytes.
// [RL26] Not-taken branches report lower count; taken ones the higher range.
// [RL27] Reserved bits read as zero.
`timescale 1ns/1ps
`include "bcit_defines.vh"
module bcit_core #(
  parameter FLASH_WAIT_W = 2
) (
  // Clock and reset
  input  wire                    sys_clk_i,
  input  wire                    nrst_i,
  // Instruction in
  input  wire                    start_i,
  input  wire [7:0]              opcode_i,
  input  wire [7:0]              operand1_i,
  input  wire [7:0]              operand2_i,
  input  wire [15:0]             pc_i,
  input  wire                    cond_true_i,
  input  wire                    misaligned_i,
  input  wire [FLASH_WAIT_W-1:0] flash_read_timing_i,
  input  wire [7:0]              acc_i,
  // Special register port
  input  wire                    sfr_wr_i,
  input  wire [7:0]              sfr_addr_i,
  input  wire [7:0]              sfr_wdata_i,
  output reg  [7:0]              sfr_rdata_o,
  // Decode results
  output reg                     busy_o,
  output reg                     done_o,
  output reg  [1:0]              bytes_o,
  output reg  [3:0]              clocks_o,
  output reg  [15:0]             target_o,
  output reg                     target_valid_o,
  output reg                     direct_is_sfr_o,
  output reg  [2:0]              bank_reg_o,
  output reg  [4:0]              bank_reg_addr_o,
  output reg                     bit_clear_o,
  output reg  [15:0]             data_pointer_o,
  output reg  [7:0]              stack_top_pointer_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  wire [1:0] t_bytes;
  wire [3:0] t_base;
  wire [3:0] t_max;
  wire [3:0] t_taken;
  wire       t_cond;

  bcit_timing u_timing (
    .opcode_i    (opcode_i),
    .bytes_o     (t_bytes),
    .clk_base_o  (t_base),
    .clk_max_o   (t_max),
    .clk_taken_o (t_taken),
    .cond_o      (t_cond)
  );

  reg        state_q;
  reg [3:0]  cnt_q;
  reg [7:0]  dp_lo_q;
  reg [7:0]  dp_hi_q;
  reg [7:0]  stk_q;
  reg [7:0]  psw_q;
  reg [3:0]  clocks_d;
  reg [15:0] target_d;
  reg        tvalid_d;
  reg [3:0]  extra;
  reg [7:0]  rel_off;
  wire [15:0] next_pc;

  assign next_pc = pc_i + {14'h0000, t_bytes};

  // Clock count with taken/not-taken choice and alignment/flash stretch.
  always @* begin
    extra = 4'd0;
    if (misaligned_i)
      extra = 4'd1;
    extra = extra + {{(4 - FLASH_WAIT_W){1'b0}}, flash_read_timing_i};
    if (t_cond && !cond_true_i)
      clocks_d = t_base; // [RL26]
    else if (t_max > t_taken + extra)
      clocks_d = t_taken + extra; // [RL21]
    else
      clocks_d = t_max;
  end

  // Branch target formation.
  always @* begin
    target_d = 16'h0000;
    tvalid_d = 1'b0;
    rel_off  = (opcode_i[3:0] == 4'h4 || opcode_i[3:0] == 4'h5 || opcode_i == 8'h10 ||
                opcode_i == 8'h20 || opcode_i == 8'h30 || opcode_i[7:3] == 5'b10111 ||
                opcode_i[7:1] == 7'b1011011)
               ? operand2_i : operand1_i; // [RL15]
    if (opcode_i[3:0] == 4'h1) begin
      target_d = {next_pc[15:`BCIT_PAGE_BITS], opcode_i[7:5], operand1_i}; // [RL17]
      tvalid_d = 1'b1;
    end else if (opcode_i == 8'h02 || opcode_i == 8'h12) begin
      target_d = {operand1_i, operand2_i}; // [RL18]
      tvalid_d = 1'b1;
    end else if (opcode_i == 8'h73) begin
      target_d = {dp_hi_q, dp_lo_q} + {8'h00, acc_i}; // [RL12]
      tvalid_d = 1'b1;
    end else if (opcode_i == 8'h80 || (t_cond && cond_true_i)) begin
      target_d = next_pc + {{8{rel_off[7]}}, rel_off}; // [RL15]
      tvalid_d = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q             <= ST_IDLE;
      cnt_q               <= 4'd0;
      busy_o              <= 1'b0;
      done_o              <= 1'b0;
      bytes_o             <= 2'd0;
      clocks_o            <= 4'd0;
      target_o            <= 16'h0000;
      target_valid_o      <= 1'b0;
      direct_is_sfr_o     <= 1'b0;
      bank_reg_o          <= 3'd0;
      bank_reg_addr_o     <= 5'd0;
      bit_clear_o         <= 1'b0;
      dp_lo_q             <= `BCIT_DP_LO_RST;
      dp_hi_q             <= `BCIT_DP_HI_RST;
      stk_q               <= `BCIT_STK_RST;
      psw_q               <= `BCIT_PSW_RST;
      sfr_rdata_o         <= 8'h00;
      data_pointer_o      <= 16'h0000;
      stack_top_pointer_o <= `BCIT_STK_RST;
    end else begin
      done_o      <= 1'b0;
      bit_clear_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            state_q         <= ST_EXEC;
            busy_o          <= 1'b1;
            cnt_q           <= clocks_d - 4'd1;
            bytes_o         <= t_bytes;
            clocks_o        <= clocks_d;
            target_o        <= target_d;
            target_valid_o  <= tvalid_d;
            direct_is_sfr_o <= operand1_i[`BCIT_REG_SPACE_BIT]; // [RL16]
            bank_reg_o      <= (opcode_i[3:1] == 3'b011) ? {2'b00, opcode_i[0]}
                               : opcode_i[2:0]; // [RL20]
            bank_reg_addr_o <= {psw_q[`BCIT_PSW_RS_LSB+1:`BCIT_PSW_RS_LSB],
                                ((opcode_i[3:1] == 3'b011) ? {2'b00, opcode_i[0]}
                                 : opcode_i[2:0])}; // [RL20]
            bit_clear_o     <= (opcode_i == 8'h10) && cond_true_i; // [RL10]
            if (opcode_i == 8'hc0)
              stk_q <= stk_q + 8'h01; // [RL24]
            else if (opcode_i == 8'hd0)
              stk_q <= stk_q - 8'h01;
            if (opcode_i == 8'h90) begin
              dp_hi_q <= operand1_i; // [RL4]
              dp_lo_q <= operand2_i;
            end else if (opcode_i == 8'ha3) begin
              {dp_hi_q, dp_lo_q} <= {dp_hi_q, dp_lo_q} + 16'h0001;
            end
            if (clocks_d == 4'd1) begin
              state_q <= ST_IDLE;
              busy_o  <= 1'b0;
              done_o  <= 1'b1; // [RL19] [RL25]
            end
          end else if (sfr_wr_i) begin
            case (sfr_addr_i)
              `BCIT_ADDR_DP_LO: dp_lo_q <= sfr_wdata_i; // [RL22]
              `BCIT_ADDR_DP_HI: dp_hi_q <= sfr_wdata_i; // [RL23]
              `BCIT_ADDR_STK:   stk_q   <= sfr_wdata_i;
              `BCIT_ADDR_PSW:   psw_q   <= sfr_wdata_i;
              default: ;
            endcase
          end
        end
        ST_EXEC: begin
          if (cnt_q <= 4'd1) begin
            state_q <= ST_IDLE;
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
          end
          cnt_q <= cnt_q - 4'd1;
        end
        default: state_q <= ST_IDLE;
      endcase
      case (sfr_addr_i)
        `BCIT_ADDR_DP_LO: sfr_rdata_o <= dp_lo_q;
        `BCIT_ADDR_DP_HI: sfr_rdata_o <= dp_hi_q;
        `BCIT_ADDR_STK:   sfr_rdata_o <= stk_q;
        `BCIT_ADDR_PSW:   sfr_rdata_o <= psw_q;
        default:          sfr_rdata_o <= 8'h00; // [RL27]
      endcase
      data_pointer_o      <= {dp_hi_q, dp_lo_q};
      stack_top_pointer_o <= stk_q;
    end
  end
endmodule // bcit_core

// ---- rtl/bcit_defines.vh ----
// Constants for the byte core instruction decode and timing block.
// Assumes inclusion by bare name from design files in rtl/.
`ifndef BCIT_DEFINES_VH
`define BCIT_DEFINES_VH
`define BCIT_ADDR_DP_LO     8'h82
`define BCIT_ADDR_DP_HI     8'h83
`define BCIT_ADDR_STK       8'h81
`define BCIT_ADDR_PSW       8'hd0
`define BCIT_DP_LO_RST      8'h00
`define BCIT_DP_HI_RST      8'h00
`define BCIT_STK_RST        8'h07
`define BCIT_PSW_RST        8'h00
`define BCIT_PSW_RS_LSB     3
`define BCIT_REG_SPACE_BIT  7
`define BCIT_OP_NOP         8'h00
`define BCIT_OP_UNUSED      8'ha5
`define BCIT_PAGE_BITS      11
`endif

// ---- rtl/bcit_timing.v ----
// Opcode classifier: byte length and clock counts (not taken, taken min, taken max).
// Assumes an 8-bit opcode; purely combinational.
`timescale 1ns/1ps
module bcit_timing (
  // Opcode in
  input  wire [7:0] opcode_i,
  // Timing out
  output reg  [1:0] bytes_o,
  output reg  [3:0] clk_base_o,
  output reg  [3:0] clk_max_o,
  output reg  [3:0] clk_taken_o,
  output reg        cond_o
);
  always @* begin
    bytes_o     = 2'd1;
    clk_base_o  = 4'd1;
    clk_max_o   = 4'd1;
    clk_taken_o = 4'd1;
    cond_o      = 1'b0;
    casez (opcode_i)
      8'h00, 8'ha5, 8'he4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
      8'hc3, 8'hd3, 8'hb3: begin // [RL1] [RL8] [RL19]
        bytes_o = 2'd1;
      end
      8'hf4: begin // [RL1]
        clk_base_o = 4'd2; clk_max_o = 4'd2; clk_taken_o = 4'd2;
      end
      8'he8, 8'he9, 8'hea, 8'heb, 8'hec, 8'hed, 8'hee, 8'hef,
      8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff: begin // [RL3] [RL20]
        bytes_o = 2'd1;
      end
      8'he6, 8'he7, 8'hf6, 8'hf7, 8'hc6, 8'hc7, 8'hd6, 8'hd7: begin // [RL3]
        clk_base_o = 4'd2; clk_max_o = 4'd2; clk_taken_o = 4'd2;
      end
      8'h43, 8'h53, 8'h63, 8'h90, 8'h85, 8'h75: begin // [RL2] [RL4]
        bytes_o = 2'd3; clk_base_o = 4'd3; clk_max_o = 4'd3; clk_taken_o = 4'd3;
      end
      8'h93: begin // [RL5] [RL21]
        clk_base_o = 4'd4; clk_max_o = 4'd7; clk_taken_o = 4'd4;
      end
      8'h83, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin // [RL5] [RL6]
        clk_base_o = 4'd3; clk_max_o = 4'd3; clk_taken_o = 4'd3;
      end
      8'hc0, 8'hd0, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92,
      8'hc2, 8'hd2, 8'hb2: begin // [RL7] [RL8]
        bytes_o = 2'd2; clk_base_o = 4'd2; clk_max_o = 4'd2; clk_taken_o = 4'd2;
      end
      8'h40, 8'h50, 8'h60, 8'h70, 8'hd8, 8'hd9, 8'hda, 8'hdb,
      8'hdc, 8'hdd, 8'hde, 8'hdf: begin // [RL9] [RL14] [RL26]
        bytes_o = 2'd2; clk_base_o = 4'd2; clk_taken_o = 4'd4; clk_max_o = 4'd6;
        cond_o = 1'b1;
      end
      8'h20, 8'h30, 8'h10, 8'hd5, 8'hb8, 8'hb9, 8'hba, 8'hbb,
      8'hbc, 8'hbd, 8'hbe, 8'hbf: begin // [RL10] [RL13] [RL14]
        bytes_o = 2'd3; clk_base_o = 4'd3; clk_taken_o = 4'd5; clk_max_o = 4'd7;
        cond_o = 1'b1;
      end
      8'hb4: begin // [RL13]
        bytes_o = 2'd3; clk_base_o = 4'd3; clk_taken_o = 4'd6; clk_max_o = 4'd8;
        cond_o = 1'b1;
      end
      8'hb5, 8'hb6, 8'hb7: begin // [RL13]
        bytes_o = 2'd3; clk_base_o = 4'd4; clk_taken_o = 4'd6; clk_max_o = 4'd8;
        cond_o = 1'b1;
      end
      8'b???1_0001, 8'b???0_0001, 8'h80: begin // [RL11]
        bytes_o = 2'd2; clk_base_o = 4'd4; clk_taken_o = 4'd4; clk_max_o = 4'd6;
      end
      8'h12, 8'h02: begin // [RL11]
        bytes_o = 2'd3; clk_base_o = 4'd5; clk_taken_o = 4'd5; clk_max_o = 4'd7;
      end
      8'h22, 8'h32: begin // [RL11]
        clk_base_o = 4'd6; clk_taken_o = 4'd6; clk_max_o = 4'd8;
      end
      8'h73: begin // [RL12]
        clk_base_o = 4'd3; clk_taken_o = 4'd3; clk_max_o = 4'd5;
      end
      default: begin // [RL25]
        bytes_o = (opcode_i[3:0] == 4'h4 || opcode_i[3:0] == 4'h5) ? 2'd2 : 2'd1;
        clk_base_o  = {2'b00, bytes_o};
        clk_max_o   = {2'b00, bytes_o};
        clk_taken_o = {2'b00, bytes_o};
      end
    endcase
  end
endmodule // bcit_timing

// ---- dv/bcit_core_assertions.sv ----
// Checker for bcit_core: instruction timing, targets and outputs at the ports.
// Assumes the design ports named as in bcit_core; attached by bind below.
`timescale 1ns/1ps
module bcit_chk (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  // Instruction in
  input wire logic        start_i,
  input wire logic [7:0]  opcode_i,
  input wire logic [7:0]  operand1_i,
  input wire logic [7:0]  operand2_i,
  input wire logic        cond_true_i,
  // Decode results
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [1:0]  bytes_o,
  input wire logic [3:0]  clocks_o,
  input wire logic [15:0] target_o,
  input wire logic        target_valid_o,
  input wire logic        direct_is_sfr_o,
  input wire logic        bit_clear_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire acc = start_i && !busy_o;
  wire op1_msb = operand1_i[7];
  property p_one_clk; acc && (opcode_i == 8'ha5 || opcode_i == 8'he4) |=> done_o && !busy_o;
  endproperty
  property p_cpl; acc && opcode_i == 8'hf4 |=> busy_o && clocks_o == 4'h2 ##1 done_o; endproperty
  property p_xrl; acc && opcode_i == 8'h63 |=> bytes_o == 2'h3 && clocks_o == 4'h3; endproperty
  property p_external_data_transfer;
    acc && opcode_i inside {8'he0, 8'he2, 8'hf0, 8'hf2} |=> bytes_o == 2'h1 && clocks_o == 4'h3;
  endproperty
  property p_nt; acc && opcode_i == 8'h40 && !cond_true_i |=> clocks_o == 4'h2 ##1 done_o;
  endproperty
  property p_ret; acc && opcode_i == 8'h22 |=> clocks_o >= 4'h6 && clocks_o <= 4'h8 ##[5:7] done_o;
  endproperty
  property p_long;
    acc && opcode_i == 8'h02 |=> target_valid_o && target_o == {$past(operand1_i), $past(operand2_i)};
  endproperty
  property p_sfr; acc |=> direct_is_sfr_o == $past(op1_msb); endproperty
  property p_jbc; acc && opcode_i == 8'h10 && cond_true_i |=> bit_clear_o ##1 !bit_clear_o;
  endproperty
  property p_done; $fell(busy_o) |-> done_o; endproperty
  a_one_clk: assert property (p_one_clk) else $error("one clock op late");
  a_cpl: assert property (p_cpl) else $error("complement timing wrong");
  a_xrl: assert property (p_xrl) else $error("logic immediate timing wrong");
  a_external_data_transfer: assert property (p_external_data_transfer) else $error("external transfer timing wrong");
  a_nt: assert property (p_nt) else $error("not taken jump timing wrong");
  a_ret: assert property (p_ret) else $error("return timing wrong");
  a_long: assert property (p_long) else $error("long target wrong");
  a_sfr: assert property (p_sfr) else $error("direct space flag wrong");
  a_jbc: assert property (p_jbc) else $error("bit clear pulse wrong");
  a_done: assert property (p_done) else $error("busy ended without done");
  c_short_jump: cover property (acc && opcode_i == 8'h80);
  c_jbc: cover property (bit_clear_o);
  c_code: cover property (acc && opcode_i == 8'h93);
endmodule // bcit_chk
bind bcit_core bcit_chk u_chk (.sys_clk_i, .nrst_i, .start_i, .opcode_i, .operand1_i,
  .operand2_i, .cond_true_i, .busy_o, .done_o, .bytes_o, .clocks_o, .target_o,
  .target_valid_o, .direct_is_sfr_o, .bit_clear_o);

// ---- dv/bcit_tb.sv ----
// Self-checking bench for bcit_core: register access and random instruction timing.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk_i, nrst_i, start_i, cond_true_i, misaligned_i, sfr_wr_i;
  logic [1:0]  flash_read_timing_i, bytes_o, bank;
  logic [7:0]  opcode_i, operand1_i, operand2_i, acc_i, sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [15:0] pc_i, target_o, data_pointer_o;
  logic        busy_o, done_o, target_valid_o, direct_is_sfr_o, bit_clear_o;
  logic [3:0]  clocks_o;
  logic [2:0]  bank_reg_o;
  logic [4:0]  bank_reg_addr_o;
  logic [7:0]  stack_top_pointer_o, d, op;
  logic [23:0] e;
  logic        c, m;
  logic [1:0]  f;
  int          errors, n_tests, cyc, p, i;
  // Each entry: opcode, bytes, not-taken or fixed clocks, taken min, taken max.
  logic [23:0] tbl [40] = '{24'he41100, 24'hf41200, 24'h231100, 24'h331100, 24'h031100,
    24'h131100, 24'hc41100,
    24'h633300, 24'he61200, 24'he81100, 24'h903300, 24'h931047, 24'h831300,
    24'he21300, 24'hf21300, 24'he01300, 24'hf01300, 24'hc02200, 24'hd02200,
    24'hc31100, 24'h822200, 24'hb02200, 24'h402246, 24'h602246, 24'h203357,
    24'h103357, 24'h112046, 24'h123057, 24'h221068, 24'h321068, 24'h802046,
    24'h023057, 24'h012046, 24'h731035, 24'hb53468, 24'hb83357,
    24'hd82246, 24'hd53357, 24'h001100, 24'ha51100};
  bcit_core #(.FLASH_WAIT_W(2)) uut (.sys_clk_i, .nrst_i, .start_i, .opcode_i, .operand1_i,
    .operand2_i, .pc_i, .cond_true_i, .misaligned_i, .flash_read_timing_i, .acc_i, .sfr_wr_i,
    .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .busy_o, .done_o, .bytes_o, .clocks_o, .target_o,
    .target_valid_o, .direct_is_sfr_o, .bank_reg_o, .bank_reg_addr_o, .bit_clear_o,
    .data_pointer_o, .stack_top_pointer_o);
  function automatic logic [15:0] exp_clk(input logic [23:0] x, input logic cc, mm,
                                          input logic [1:0] ff);
    logic [4:0] t;
    t = x[7:4] + mm + ff;
    if (x[7:4] == 4'h0 || (x[11:8] != 4'h0 && !cc)) return {12'h0, x[11:8]};
    return (t > x[3:0]) ? {12'h0, x[3:0]} : {11'h0, t};
  endfunction
  task automatic summarize();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, dd);
    @(posedge sys_clk_i); #5;
    {sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {1'b1, a, dd};
    @(posedge sys_clk_i); #5;
    sfr_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a, x);
    @(posedge sys_clk_i); #5;
    sfr_addr_i = a;
    @(posedge sys_clk_i); #5;
    check(sfr_rdata_o, x);
  endtask
  task automatic run();
    logic [7:0] o1, o2, sp0;
    logic [15:0] pc, nx, tg, dp0;
    logic tv;
    int k;
    o1 = $urandom;
    o2 = $urandom;
    pc = $urandom;
    sp0 = stack_top_pointer_o;
    dp0 = data_pointer_o;
    nx = pc + 16'h2;
    @(posedge sys_clk_i); #5;
    {start_i, opcode_i, operand1_i, operand2_i, pc_i, acc_i} = {1'b1, op, o1, o2, pc, o2};
    {cond_true_i, misaligned_i, flash_read_timing_i} = {c, m, f};
    @(posedge sys_clk_i); #5;
    start_i = busy_o;
    opcode_i = 8'he4;
    k = 1;
    while (done_o !== 1'b1 && k < 20) begin
      @(posedge sys_clk_i); #5;
      start_i = 0;
      k++;
    end
    check(k[15:0], exp_clk(e, c, m, f));
    @(posedge sys_clk_i); #5;
    check(clocks_o, exp_clk(e, c, m, f));
    check(bytes_o, e[13:12]);
    check(direct_is_sfr_o, o1[7]);
    tg = (op[4:0] == 5'h01) ? {nx[15:11], op[7:5], o1} : (op == 8'h02) ? {o1, o2} :
         nx + {{8{o1[7]}}, o1};
    if (op == 8'h80 || (op == 8'h40 && c) || op[4:0] == 5'h01 || op == 8'h02)
      check(target_o, tg);
    if (c && e[11:8] != 4'h0 && e[7:4] != 4'h0 && e[15:12] == 4'h3)
      check(target_o, pc + 16'h3 + {{8{o2[7]}}, o2});
    if (op == 8'h73) check(target_o, dp0 + {8'h00, o2});
    tv = op[3:0] == 4'h1 || op == 8'h02 || op == 8'h12 || op == 8'h73 || op == 8'h80;
    tv = tv || (c && e[11:8] != 4'h0 && e[7:4] != 4'h0);
    check(target_valid_o, tv);
    if (op[7:3] == 5'h1d) check(bank_reg_addr_o, {bank, op[2:0]});
    if (op[7:3] == 5'h1d) check(bank_reg_o, op[2:0]);
    if (op[7:1] == 7'h73) check(bank_reg_o, {2'b00, op[0]});
    if (op == 8'hc0) check(stack_top_pointer_o, sp0 + 8'h1);
    if (op == 8'h90) check(data_pointer_o, {o1, o2});
  endtask
  initial begin
    sys_clk_i = 0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    {nrst_i, start_i, cond_true_i, misaligned_i, sfr_wr_i, flash_read_timing_i} = 0;
    {opcode_i, operand1_i, operand2_i, acc_i, sfr_addr_i, sfr_wdata_i, pc_i} = 0;
    void'($urandom(16228));
    repeat (16) @(posedge sys_clk_i);
    #5 nrst_i = 1;
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'h81, 8'h07);
    check(stack_top_pointer_o, 8'h07);
    d = $urandom;
    wr(8'h82, d);
    wr(8'h83, ~d);
    rd(8'h82, d);
    rd(8'h83, ~d);
    check(data_pointer_o, {~d, d});
    wr(8'h9a, 8'hff);
    rd(8'h9a, 8'h00);
    for (p = 0; p < 3; p++) begin
      for (i = 0; i < (p < 2 ? 40 : 240); i++) begin
        if (i % 16 == 0) begin
          bank = $urandom;
          wr(8'hd0, {3'h0, bank, 3'h0});
        end
        e = tbl[p < 2 ? i : $urandom_range(39)];
        op = e[23:16];
        if (op[3:0] == 4'h8) op[2:0] = $urandom;
        if (op == 8'h01) op[7:5] = $urandom;
        {c, m, f} = (p == 2) ? 4'($urandom) : {4{p[0]}};
        run();
      end
    end
    summarize();
  end
endmodule // testbench
